// [raw_event_ctrl.sv]
/*
 * Alarm comparator, watchdog, power fail effects, flags register and
 * the shared interrupt pin driver of a real time clock.
 * Assumes time counters in BCD on the same clock, and the 32 Hz tick,
 * oscillator, power fail and backup indications arriving as pins.
 */
// Functional notes
// - Compare alarm fields against current time counters.
// - A field counts only when its mask is zero.
// - All masks set means alarm disabled.
// - All masks clear means exact time match.
// - A match sets the alarm flag.
// - Reading flags clears all event flags.
// - Watchdog counts 32 Hz ticks while oscillator runs.
// - Load at power-up, reload on strobe.
// - Reaching zero sets timeout flag, maybe interrupt.
// - Write protect keeps timeout value, strobe acts.
// - Timeout value zero disables the watchdog.
// - Watchdog interrupt enable; flag read clears the timeout flag, not the enable.
// - On backup supply register access is blocked.
// - Interrupt needs a set flag and enable.
// - Pulse mode drives output about 200 ms.
// - Level mode holds output until flags read.
// - Flags read ends a running pulse early.
// - Polarity selects push-pull high or open-drain low.
// - No interrupts while on backup supply.
// - Flags reset to zero, oscillator flag excepted; reset here clears it too.
`timescale 1ns/1ps
`include "raw_cfg.svh"

module raw_event_ctrl
    import raw_pkg::*;
#(
    parameter int unsigned PulseCycles = `RAW_PULSE_CYC
)
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic [`RAW_ADDR_W-1:0] regAddr,
    input  wire logic [7:0]             regWrData,
    input  wire logic                   regWrStrobe,
    input  wire logic                   regRdStrobe,
    output logic      [7:0]             regRdData,
    input  wire logic [6:0]             curSeconds,
    input  wire logic [6:0]             curMinutes,
    input  wire logic [5:0]             curHours,
    input  wire logic [5:0]             curDate,
    input  wire logic                   tick32Pin,
    input  wire logic                   oscRunningPin,
    input  wire logic                   powerFailPin,
    input  wire logic                   onBackupPin,
    input  wire logic                   oscFailDetect,
    output logic                        intOut,
    output logic                        intOe
);

    localparam logic [`RAW_PULSE_CNT_W-1:0] PULSE_LAST =
        `RAW_PULSE_CNT_W'(PulseCycles - 1);

    raw_state_type s_q;
    raw_state_type s_d;

    logic       almSet;
    logic       wdfSet;
    logic       pfSet;
    logic       match;
    logic       wrOk;
    logic       rdOk;
    logic [3:0] pinIn;

    assign pinIn = {onBackupPin, powerFailPin, oscRunningPin, tick32Pin};

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    // All behaviour lives in one combinational pass over a copy of the
    // state; ordering of the steps below sets the priorities.
    always_comb
    begin
        logic [3:0][6:0] cur;
        logic            allMasked;
        logic            tick;
        logic            newIrq;
        logic            active;
        cur       = {{1'b0, curDate}, {1'b0, curHours}, curMinutes,
                     curSeconds};
        allMasked = 1'b1;
        match     = 1'b1;
        // Every local starts defined so that no path leaves a latch.
        tick      = 1'b0;
        newIrq    = 1'b0;
        active    = 1'b0;
        s_d       = s_q;

        // Three-stage pin synchronisers; a change counts once the
        // second and third stages agree, which rejects single glitches.
        for (int i = 0; i < 4; i++)
        begin
            s_d.sync[i] = {s_q.sync[i][1:0], pinIn[i]};
            if (s_q.sync[i][1] == s_q.sync[i][2])
            begin
                s_d.level[i] = s_q.sync[i][2];
            end
        end
        tick = s_d.level[`RAW_SY_TICK] & ~s_q.level[`RAW_SY_TICK];

        // Backup supply blocks every register access.
        wrOk = regWrStrobe & ~s_q.level[`RAW_SY_BACKUP];
        rdOk = regRdStrobe & ~s_q.level[`RAW_SY_BACKUP];

        // Alarm comparison over the active copy of the alarm fields.
        for (int i = 0; i < 4; i++)
        begin
            if (!s_q.almAct[i][`RAW_ALM_MASK])
            begin
                allMasked = 1'b0;
                if (s_q.almAct[i][6:0] != cur[i])
                begin
                    match = 1'b0;
                end
            end
        end
        match      = match & ~allMasked;
        almSet     = match & ~s_q.matchPrev;
        s_d.matchPrev = match;
        pfSet      = s_d.level[`RAW_SY_PFAIL] & ~s_q.level[`RAW_SY_PFAIL];
        wdfSet     = 1'b0;

        // Watchdog: counts only on a tick with the oscillator running.
        if (tick && s_q.level[`RAW_SY_OSC] && s_q.wdtVal != 6'h00)
        begin
            if (s_q.wdtCnt == 6'h00)
            begin
                s_d.wdtCnt = s_q.wdtVal;
            end
            else if (s_q.wdtCnt == 6'h01)
            begin
                wdfSet     = 1'b1;
                s_d.wdtCnt = s_q.wdtVal;
            end
            else
            begin
                s_d.wdtCnt = s_q.wdtCnt - 6'h01;
            end
        end

        // Flags read clears the events; a set in the same cycle wins.
        s_d.rdData = 8'h00;
        if (rdOk)
        begin
            case (regAddr)
                `RAW_OFF_FLAGS:
                begin
                    s_d.rdData = {s_q.watchdog_timeout_flag, s_q.af, s_q.pf, s_q.oscillator_failure_flag, 1'b0,
                                  s_q.cal, s_q.wBit, s_q.rBit};
                    s_d.watchdog_timeout_flag = 1'b0;
                    s_d.af  = 1'b0;
                    s_d.pf  = 1'b0;
                end
                `RAW_OFF_ALM_SEC:  s_d.rdData = s_q.almStage[0];
                `RAW_OFF_ALM_MIN:  s_d.rdData = s_q.almStage[1];
                `RAW_OFF_ALM_HOUR: s_d.rdData = s_q.almStage[2];
                `RAW_OFF_ALM_DATE: s_d.rdData = s_q.almStage[3];
                `RAW_OFF_INT_CTL:  s_d.rdData = s_q.intCtl;
                `RAW_OFF_WDOG:     s_d.rdData = {1'b0, s_q.watchdog_value_write_protect, s_q.wdtVal};
                default:           s_d.rdData = 8'h00;
            endcase
        end

        // Register writes.
        if (wrOk)
        begin
            case (regAddr)
                `RAW_OFF_FLAGS:
                begin
                    s_d.cal  = regWrData[`RAW_FLG_CAL];
                    s_d.wBit = regWrData[`RAW_FLG_W];
                    s_d.rBit = regWrData[`RAW_FLG_R];
                    if (s_q.wBit && !regWrData[`RAW_FLG_OSCILLATOR_FAILURE_FLAG])
                    begin
                        s_d.oscillator_failure_flag = 1'b0;
                    end
                    // Alarm values take effect when the unlock drops.
                    if (s_q.wBit && !regWrData[`RAW_FLG_W])
                    begin
                        s_d.almAct = s_q.almStage;
                    end
                end
                `RAW_OFF_ALM_SEC:  s_d.almStage[0] = regWrData;
                `RAW_OFF_ALM_MIN:  s_d.almStage[1] = regWrData;
                `RAW_OFF_ALM_HOUR: s_d.almStage[2] = regWrData;
                `RAW_OFF_ALM_DATE: s_d.almStage[3] = regWrData;
                `RAW_OFF_INT_CTL:
                    s_d.intCtl = regWrData & 8'hec;
                `RAW_OFF_WDOG:
                begin
                    s_d.watchdog_value_write_protect = regWrData[`RAW_WD_WDW];
                    if (!regWrData[`RAW_WD_WDW])
                    begin
                        s_d.wdtVal = regWrData[5:0];
                    end
                    if (regWrData[`RAW_WD_WDS])
                    begin
                        s_d.wdtCnt = s_d.wdtVal;
                    end
                end
                default: ;
            endcase
        end

        // Hardware sets come last so that they win over any clear.
        s_d.af = s_d.af | almSet;
        s_d.watchdog_timeout_flag = s_d.watchdog_timeout_flag | wdfSet;
        s_d.pf = s_d.pf | pfSet;
        s_d.oscillator_failure_flag = s_d.oscillator_failure_flag | oscFailDetect;

        // Enabled sources, suppressed while running on backup.
        s_d.irqCond = ((s_d.watchdog_timeout_flag & s_d.intCtl[`RAW_ICTL_WIE])
                     | (s_d.af & s_d.intCtl[`RAW_ICTL_AIE])
                     | (s_d.pf & s_d.intCtl[`RAW_ICTL_PFE]))
                     & ~s_d.level[`RAW_SY_BACKUP];
        newIrq = s_d.irqCond & ~s_q.irqCond;

        // Pulse timer; it ends early once the flags read drops the cause.
        s_d.pulseCnt = '0;
        case (s_q.intState)
            INT_IDLE:
            begin
                if (newIrq && s_d.intCtl[`RAW_ICTL_PL])
                begin
                    s_d.intState = INT_PULSE;
                end
            end
            INT_PULSE:
            begin
                s_d.pulseCnt = s_q.pulseCnt + 1'b1;
                if (!s_d.irqCond || s_q.pulseCnt == PULSE_LAST)
                begin
                    s_d.intState = INT_IDLE;
                end
            end
            default: s_d.intState = INT_IDLE;
        endcase

        active = s_d.intCtl[`RAW_ICTL_PL] ? (s_d.intState == INT_PULSE)
                                          : s_d.irqCond;

        // Push-pull high drives only on main power; else open drain low.
        if (s_d.intCtl[`RAW_ICTL_HL])
        begin
            s_d.intOut = active;
            s_d.intOe  = ~s_d.level[`RAW_SY_BACKUP];
        end
        else
        begin
            s_d.intOut = 1'b0;
            s_d.intOe  = active;
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    // The watchdog count starts from the stored value at power-up.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s_q          <= '0;
            s_q.almStage <= {4{`RAW_ALM_RST}};
            s_q.almAct   <= {4{`RAW_ALM_RST}};
            s_q.intCtl   <= `RAW_ICTL_RST;
            s_q.wdtVal   <= `RAW_WDT_RST;
            s_q.wdtCnt   <= `RAW_WDT_RST;
            s_q.intState <= INT_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign regRdData = s_q.rdData;
    assign intOut    = s_q.intOut;
    assign intOe     = s_q.intOe;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence flagsRead;
        rdOk && regAddr == `RAW_OFF_FLAGS;
    endsequence

    sequence quietRead;
        flagsRead ##0 (!almSet && !wdfSet && !pfSet);
    endsequence

    AST_READ_CLEARS: assert property (quietRead |=>
        !s_q.af && !s_q.watchdog_timeout_flag && !s_q.pf)
        else $error("Flags read did not clear the event flags.");

    AST_SET_WINS: assert property (flagsRead ##0 almSet |=> s_q.af)
        else $error("Alarm set lost against a flags read.");

    AST_ALARM_OFF: assert property ((&{s_q.almAct[0][7],
        s_q.almAct[1][7], s_q.almAct[2][7], s_q.almAct[3][7]}) |-> !almSet)
        else $error("Alarm fired with every field masked.");

    AST_WDT_OFF: assert property (s_q.wdtVal == 6'h00 |-> !wdfSet)
        else $error("Watchdog timed out while disabled.");

    AST_WDW_KEEP: assert property (wrOk && regAddr == `RAW_OFF_WDOG
        && regWrData[`RAW_WD_WDW] |=> s_q.wdtVal == $past(s_q.wdtVal))
        else $error("Protected timeout value changed.");

    AST_STROBE_LOAD: assert property (wrOk && regAddr == `RAW_OFF_WDOG
        && regWrData[`RAW_WD_WDS] |=> s_q.wdtCnt == s_q.wdtVal)
        else $error("Strobe did not reload the watchdog count.");

    AST_NO_BACKUP_IRQ: assert property (s_q.level[`RAW_SY_BACKUP]
        |-> !s_q.irqCond && !(s_q.intOe && s_q.intOut == s_q.intCtl[3]))
        else $error("Interrupt active on backup supply.");

    AST_LEVEL_HOLD: assert property (!s_q.intCtl[`RAW_ICTL_PL]
        && s_q.intCtl[`RAW_ICTL_HL] |-> s_q.intOut == s_q.irqCond)
        else $error("Level mode output does not follow the flags.");

    AST_PULSE_START: assert property (s_q.intState == INT_IDLE
        ##1 ($rose(s_q.irqCond) && s_q.intCtl[`RAW_ICTL_PL])
        |-> s_q.intState == INT_PULSE)
        else $error("Pulse did not start on a new interrupt.");

    AST_PULSE_END: assert property (s_q.intState == INT_PULSE
        && !s_q.pf && !s_q.af && !s_q.watchdog_timeout_flag |-> ##1 s_q.intState == INT_IDLE)
        else $error("Pulse went on without a cause.");

endmodule : raw_event_ctrl

// [raw_cfg.svh]
/*
 * Offsets, field positions, reset values and timing counts of the
 * alarm, watchdog and interrupt event logic.
 * Assumes a 20-bit byte address and an 8-bit register data path.
 */
`ifndef RAW_CFG_SVH
`define RAW_CFG_SVH

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define RAW_ADDR_W        20
`define RAW_OFF_FLAGS     20'hffff0
`define RAW_OFF_ALM_SEC   20'hffff2
`define RAW_OFF_ALM_MIN   20'hffff3
`define RAW_OFF_ALM_HOUR  20'hffff4
`define RAW_OFF_ALM_DATE  20'hffff5
`define RAW_OFF_INT_CTL   20'hffff6
`define RAW_OFF_WDOG      20'hffff7

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define RAW_FLG_WDF       7
`define RAW_FLG_AF        6
`define RAW_FLG_PF        5
`define RAW_FLG_OSCILLATOR_FAILURE_FLAG      4
`define RAW_FLG_CAL       2
`define RAW_FLG_W         1
`define RAW_FLG_R         0
`define RAW_ICTL_WIE      7
`define RAW_ICTL_AIE      6
`define RAW_ICTL_PFE      5
`define RAW_ICTL_HL       3
`define RAW_ICTL_PL       2
`define RAW_WD_WDS        7
`define RAW_WD_WDW        6
`define RAW_ALM_MASK      7

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define RAW_ALM_RST       8'h80
`define RAW_ICTL_RST      8'h08
`define RAW_WDT_RST       6'h00

// ---------------------------------------------------------------------
// Input synchroniser slots and timing
// ---------------------------------------------------------------------
`define RAW_SY_TICK       0
`define RAW_SY_OSC        1
`define RAW_SY_PFAIL      2
`define RAW_SY_BACKUP     3
`define RAW_CLK_HZ        40000000
`define RAW_PULSE_MS      200
`define RAW_PULSE_CYC     (`RAW_PULSE_MS * (`RAW_CLK_HZ / 1000))
`define RAW_PULSE_CNT_W   23

`endif

// [raw_pkg.sv]
/*
 * Types of the alarm, watchdog and interrupt event logic.
 * Assumes raw_cfg.svh is on the include path.
 */
`include "raw_cfg.svh"

package raw_pkg;

    // -----------------------------------------------------------------
    // Interrupt driver states
    // -----------------------------------------------------------------
    typedef enum logic {
        INT_IDLE,
        INT_PULSE
    } raw_int_state_type;

    // -----------------------------------------------------------------
    // Complete state of the block
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [3:0][2:0]                 sync;
        logic [3:0]                      level;
        logic [3:0][7:0]                 almStage;
        logic [3:0][7:0]                 almAct;
        logic [7:0]                      intCtl;
        logic [5:0]                      wdtVal;
        logic                            watchdog_value_write_protect;
        logic [5:0]                      wdtCnt;
        logic                            watchdog_timeout_flag;
        logic                            af;
        logic                            pf;
        logic                            oscillator_failure_flag;
        logic                            cal;
        logic                            wBit;
        logic                            rBit;
        logic                            matchPrev;
        logic                            irqCond;
        raw_int_state_type               intState;
        logic [`RAW_PULSE_CNT_W-1:0]     pulseCnt;
        logic [7:0]                      rdData;
        logic                            intOut;
        logic                            intOe;
    } raw_state_type;

endpackage : raw_pkg

// [raw_host_model.sv]
/*
 * Host side of the shared interrupt pin: resolves the wire level and
 * flags when pin activity may be trusted after power-up.
 * Assumes a pull-up on the pin and the block's reset on the same clock.
 */
`timescale 1ns/1ps

module raw_host_model
#(
    parameter int unsigned RecallCycles = 16
)
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic intOut,
    input  wire logic intOe,
    output logic      intPin,
    output logic      intValid
);
    int unsigned recallCnt;

    // The pull-up sets the level whenever the driver lets go.
    assign intPin = intOe ? intOut : 1'b1;

    // Activity on the pin is disregarded until the recall span ends.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            recallCnt <= 0;
        end
        else if (recallCnt < RecallCycles)
        begin
            recallCnt <= recallCnt + 1;
        end
    end
    assign intValid = (recallCnt == RecallCycles);
endmodule : raw_host_model

// [rtc_alarm_watchdog_interrupt_tb.sv]
/*
 * Self-checking bench of the alarm, watchdog and interrupt logic.
 * Assumes raw_cfg.svh and raw_pkg; the pulse is shortened to 20 cycles.
 */
`timescale 1ns/1ps
`include "raw_cfg.svh"

module rtc_alarm_watchdog_interrupt_tb
    import raw_pkg::*;
;
    localparam logic [19:0] FLG  = `RAW_OFF_FLAGS;
    localparam logic [19:0] ASEC = `RAW_OFF_ALM_SEC;
    localparam logic [19:0] AMIN = `RAW_OFF_ALM_MIN;
    localparam logic [19:0] AHR  = `RAW_OFF_ALM_HOUR;
    localparam logic [19:0] ADT  = `RAW_OFF_ALM_DATE;
    localparam logic [19:0] ICTL = `RAW_OFF_INT_CTL;
    localparam logic [19:0] WDG  = `RAW_OFF_WDOG;

    logic        ref_clk;
    logic        rst_n;
    logic [19:0] regAddr;
    logic [7:0]  regWrData;
    logic        regWrStrobe;
    logic        regRdStrobe;
    logic [7:0]  regRdData;
    logic [6:0]  curSeconds;
    logic [6:0]  curMinutes;
    logic [5:0]  curHours;
    logic [5:0]  curDate;
    logic        tick32Pin;
    logic        oscRunningPin;
    logic        powerFailPin;
    logic        onBackupPin;
    logic        oscFailDetect;
    logic        intOut;
    logic        intOe;
    logic        intPin;
    logic        intValid;
    int          bad_count;
    int          checks;

    raw_event_ctrl #(.PulseCycles(20)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .curSeconds(curSeconds), .curMinutes(curMinutes),
        .curHours(curHours), .curDate(curDate), .tick32Pin(tick32Pin),
        .oscRunningPin(oscRunningPin), .powerFailPin(powerFailPin),
        .onBackupPin(onBackupPin), .oscFailDetect(oscFailDetect),
        .intOut(intOut), .intOe(intOe));

    raw_host_model #(.RecallCycles(16)) host (
        .ref_clk(ref_clk), .rst_n(rst_n), .intOut(intOut),
        .intOe(intOe), .intPin(intPin), .intValid(intValid));

    // -----------------------------------------------------------------
    // Access tasks
    // -----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        regAddr     <= a;
        regWrData   <= d;
        regWrStrobe <= 1'b1;
        @(posedge ref_clk);
        regWrStrobe <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        regAddr     <= a;
        regRdStrobe <= 1'b1;
        @(posedge ref_clk);
        regRdStrobe <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, regRdData);
        @(posedge ref_clk);
    endtask : rd

    // Push-pull counts as active only while driven high.
    task automatic pin(input logic hl, input logic e);
        #1 chk("interrupt active", {7'h0, e},
               {7'h0, hl ? (intOe & intOut) : ~intPin});
        @(posedge ref_clk);
    endtask : pin

    task automatic tick();
        tick32Pin <= 1'b1;
        cyc(6);
        tick32Pin <= 1'b0;
        cyc(6);
    endtask : tick

    // A fresh rising edge of the seconds match.
    task automatic hit();
        curSeconds <= 7'h31;
        cyc(2);
        curSeconds <= 7'h30;
        cyc(3);
    endtask : hit

    task automatic end_sim();
        $display("Checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // A hang is cut short well beyond the length of the tests.
    initial
    begin
        cyc(5000);
        bad_count++;
        end_sim();
    end

    // -----------------------------------------------------------------
    // Tests
    // -----------------------------------------------------------------
    initial
    begin
        bad_count = 0;
        checks = 0;
        rst_n = 1'b0;
        regAddr = '0;
        regWrData = '0;
        regWrStrobe = 1'b0;
        regRdStrobe = 1'b0;
        {curSeconds, curMinutes, curHours, curDate} = {7'h30, 7'h15,
                                                        6'h12, 6'h01};
        {tick32Pin, powerFailPin, onBackupPin, oscFailDetect} = '0;
        oscRunningPin = 1'b1;
        cyc(6);
        rst_n <= 1'b1;
        cyc(20);
        chk("recall done", 8'h01, {7'h0, intValid});
        rd(FLG, 8'h00);
        rd(ASEC, 8'h80);
        rd(ICTL, 8'h08);
        rd(WDG, 8'h00);
        rd(20'hffff1, 8'h00);
        $display("Test reset finished");
        // Watchdog counts, reloads, protects its value and times out.
        wr(WDG, 8'h03);
        wr(WDG, 8'h83);
        tick();
        tick();
        rd(FLG, 8'h00);
        wr(WDG, 8'hc0);
        tick();
        tick();
        rd(FLG, 8'h00);
        tick();
        rd(FLG, 8'h80);
        rd(WDG, 8'h43);
        wr(WDG, 8'h45);
        rd(WDG, 8'h43);
        wr(WDG, 8'hc0);
        oscRunningPin <= 1'b0;
        repeat (4) tick();
        rd(FLG, 8'h00);
        oscRunningPin <= 1'b1;
        cyc(6);
        wr(ICTL, 8'h88);
        wr(WDG, 8'hc0);
        repeat (3) tick();
        pin(1'b1, 1'b1);
        rd(FLG, 8'h80);
        pin(1'b1, 1'b0);
        wr(WDG, 8'h00);
        wr(WDG, 8'h80);
        repeat (5) tick();
        rd(FLG, 8'h00);
        $display("Test watchdog finished");
        // Alarm compare with all, none and some fields masked.
        curDate <= 6'h21;
        cyc(3);
        rd(FLG, 8'h00);
        curDate <= 6'h01;
        wr(FLG, 8'h02);
        wr(ASEC, 8'h30);
        wr(AMIN, 8'h15);
        wr(AHR, 8'h12);
        wr(ADT, 8'h21);
        wr(FLG, 8'h00);
        cyc(3);
        rd(FLG, 8'h00);
        curDate <= 6'h21;
        cyc(3);
        rd(FLG, 8'h40);
        rd(FLG, 8'h00);
        wr(FLG, 8'h02);
        wr(ADT, 8'ha1);
        wr(AHR, 8'h92);
        wr(AMIN, 8'h95);
        wr(FLG, 8'h00);
        {curSeconds, curMinutes, curHours, curDate} <= {7'h31, 7'h44,
                                                         6'h03, 6'h05};
        cyc(3);
        curSeconds <= 7'h30;
        cyc(3);
        rd(FLG, 8'h40);
        $display("Test alarm finished");
        // Pin modes: level, open drain, pulse and early end of a pulse.
        wr(ICTL, 8'h48);
        hit();
        pin(1'b1, 1'b1);
        rd(FLG, 8'h40);
        pin(1'b1, 1'b0);
        wr(ICTL, 8'h40);
        hit();
        pin(1'b0, 1'b1);
        rd(FLG, 8'h40);
        pin(1'b0, 1'b0);
        wr(ICTL, 8'h4c);
        hit();
        pin(1'b1, 1'b1);
        cyc(25);
        pin(1'b1, 1'b0);
        rd(FLG, 8'h40);
        hit();
        pin(1'b1, 1'b1);
        rd(FLG, 8'h40);
        pin(1'b1, 1'b0);
        $display("Test pin modes finished");
        // Power fail raises the pin; an alarm with its interrupt disabled does not.
        wr(ICTL, 8'h28);
        powerFailPin <= 1'b1;
        cyc(6);
        pin(1'b1, 1'b1);
        rd(FLG, 8'h20);
        pin(1'b1, 1'b0);
        powerFailPin <= 1'b0;
        hit();
        pin(1'b1, 1'b0);
        rd(FLG, 8'h40);
        // On backup supply access is refused and no interrupt comes.
        wr(ICTL, 8'h48);
        onBackupPin <= 1'b1;
        cyc(6);
        hit();
        pin(1'b1, 1'b0);
        rd(FLG, 8'h00);
        wr(ICTL, 8'h00);
        onBackupPin <= 1'b0;
        cyc(6);
        rd(ICTL, 8'h48);
        $display("Test power finished");
        end_sim();
    end
endmodule : rtc_alarm_watchdog_interrupt_tb
